// file: core/dcc_pkg.sv
// constants and types shared by the dual comparator control block
package dcc_pkg;

    typedef logic [15:0] dcc_addr_t;
    typedef logic [31:0] dcc_word_t;
    typedef logic [7:0] dcc_ctrl_t;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL0 = 12'hF90;
    localparam logic [11:0] IDX_CTRL1 = 12'hF91;
    localparam logic [11:0] IDX_IRQ_STAT = 12'hF92;
    localparam logic [11:0] IDX_IRQ_MASK = 12'hF93;
    localparam logic [11:0] IDX_WAKE_STAT = 12'hF94;
    localparam logic [11:0] IDX_POWER = 12'hF95;

    // control register fields
    localparam int POS_SEL_BIT = 7;
    localparam int NEG_SEL_BIT = 6;
    localparam int REF_LSB = 2;
    localparam int REF_MSB = 5;
    localparam int TRIG_LSB = 0;
    localparam int TRIG_MSB = 1;

    // wake status fields
    localparam int WAKE_STOP_BIT = 0;
    localparam int WAKE_REQ_BIT = 1;

    // power fields: bits 1:0 power per channel, bits 3:2 keep on in stop
    localparam int PWR_ON_LSB = 0;
    localparam int PWR_KEEP_LSB = 2;

    // reset values
    localparam dcc_ctrl_t CTRL_RST = 8'h14;
    localparam logic [3:0] POWER_RST = 4'h3;
    localparam logic [1:0] MASK_RST = 2'h0;

    // trigger route codes
    localparam logic [1:0] TRIG_OFF = 2'h0;
    localparam logic [1:0] TRIG_T0 = 2'h1;
    localparam logic [1:0] TRIG_T1 = 2'h2;
    localparam logic [1:0] TRIG_T2 = 2'h3;

    // register selector codes
    typedef enum logic [2:0] {
        SEL_CTRL0 = 3'h0,
        SEL_CTRL1 = 3'h1,
        SEL_STAT = 3'h2,
        SEL_MASK = 3'h3,
        SEL_WAKE = 3'h4,
        SEL_POWER = 3'h5,
        SEL_NONE = 3'h7
    } dcc_sel_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACC = 2'b10
    } dcc_bus_st_t;

endpackage

// file: core/dcc_chan.sv
// one comparator channel: output synchroniser and edge event
`timescale 1ns/1ps
module dcc_chan (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmp_raw,
    input wire logic active,
    output logic level,
    output logic rise
);
    import dcc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } dcc_chan_st_t;

    dcc_chan_st_t cur_r;
    dcc_chan_st_t cur_nxt;

    always_comb begin
        cur_nxt = cur_r;
        // three stage capture of the analog output
        cur_nxt.s1 = cmp_raw;
        cur_nxt.s2 = cur_r.s1;
        cur_nxt.s3 = cur_r.s2;
        cur_nxt.rise = 1'b0;
        if (!active) begin
            // powered down: output held low
            cur_nxt.lvl = 1'b0;
        end else if (cur_r.s2 == cur_r.s3) begin
            cur_nxt.lvl = cur_r.s3;
            cur_nxt.rise = cur_r.s3 && !cur_r.lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign level = cur_r.lvl;
    assign rise = cur_r.rise;

endmodule

// file: core/dcc_top.sv
// dual comparator control: registers, routing, interrupts and stop wake
//
// Contract
// - positive select: pin or temperature sensor
// - negative select: pin or internal reference
// - four bit reference level, 0.2 V steps
// - reference level resets to code 0101
// - trigger route: off, timer 0, 1, 2
// - two identical channels, independent routes
// - output feeds interrupt and a pin
// - stop mode event starts recovery, raises request
// - stop recovery sets stop indication
// - wake sets comparator request bit
// - request serviced after recovery if enabled
// - power down or keep running in stop
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module dcc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire dcc_pkg::dcc_addr_t paddr,
    input wire dcc_pkg::dcc_word_t pwdata,
    output dcc_pkg::dcc_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp0_raw,
    input wire logic comp1_raw,
    input wire logic stop_mode,
    input wire logic cpu_irq_en,
    input wire logic vec_ack,
    output logic comp0_pos_select,
    output logic comp1_pos_select,
    output logic comp0_neg_select,
    output logic comp1_neg_select,
    output logic [3:0] comp0_ref_level_code,
    output logic [3:0] comp1_ref_level_code,
    output logic comp0_power_on,
    output logic comp1_power_on,
    output logic [2:0] timer_trig,
    output logic comp0_out_pin,
    output logic comp1_out_pin,
    output logic irq,
    output logic stop_recover,
    output logic cmp_vec_req
);
    import dcc_pkg::*;

    typedef struct packed {
        dcc_bus_st_t st;
        logic [1:0][7:0] ctrl;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic stop_flag;
        logic cmp_req;
        logic [3:0] power;
        logic [1:0] pwr_on;
        logic [31:0] rdata;
        logic rdy;
        logic err;
        logic [2:0] trig;
        logic [1:0] pin;
        logic irq;
        logic stop_rec;
        logic vec_req;
    } dcc_state_t;

    dcc_state_t cur_r;
    dcc_state_t cur_nxt;

    logic [1:0] lvl;
    logic [1:0] rise;

    // map a byte address to a register selector
    function automatic dcc_sel_t reg_sel(input dcc_addr_t addr);
        logic [11:0] idx;
        idx = addr[13:2];
        reg_sel = SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[15:14] == 2'h0) begin
            case (idx)
                IDX_CTRL0: reg_sel = SEL_CTRL0;
                IDX_CTRL1: reg_sel = SEL_CTRL1;
                IDX_IRQ_STAT: reg_sel = SEL_STAT;
                IDX_IRQ_MASK: reg_sel = SEL_MASK;
                IDX_WAKE_STAT: reg_sel = SEL_WAKE;
                IDX_POWER: reg_sel = SEL_POWER;
                default: reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // trigger code for a channel's route field
    function automatic logic [1:0] route_of(input logic [7:0] c);
        route_of = c[TRIG_MSB:TRIG_LSB];
    endfunction

    // two identical channels
    dcc_chan u_chan0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .cmp_raw(comp0_raw),
        .active(cur_r.pwr_on[0]),
        .level(lvl[0]),
        .rise(rise[0])
    );

    dcc_chan u_chan1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .cmp_raw(comp1_raw),
        .active(cur_r.pwr_on[1]),
        .level(lvl[1]),
        .rise(rise[1])
    );

    always_comb begin
        dcc_sel_t sel;
        logic done;
        logic [1:0] hit;
        logic [2:0] tr;
        sel = reg_sel(paddr);
        done = psel && penable && cur_r.rdy;
        hit = 2'h0;
        tr = 3'h0;
        cur_nxt = cur_r;
        cur_nxt.rdy = 1'b0;
        cur_nxt.err = 1'b0;
        cur_nxt.stop_rec = 1'b0;

        // bus state: setup, then one access cycle with ready
        unique case (cur_r.st)
            BUS_IDLE: begin
                if (psel && !penable) begin
                    cur_nxt.st = BUS_ACC;
                    cur_nxt.rdy = 1'b1;
                    cur_nxt.err = (sel == SEL_NONE);
                    cur_nxt.rdata = 32'h0000_0000;
                    case (sel)
                        SEL_CTRL0: cur_nxt.rdata[7:0] = cur_r.ctrl[0];
                        SEL_CTRL1: cur_nxt.rdata[7:0] = cur_r.ctrl[1];
                        SEL_STAT: cur_nxt.rdata[1:0] = cur_r.irq_stat;
                        SEL_MASK: cur_nxt.rdata[1:0] = cur_r.irq_mask;
                        SEL_WAKE: begin
                            cur_nxt.rdata[WAKE_STOP_BIT] = cur_r.stop_flag;
                            cur_nxt.rdata[WAKE_REQ_BIT] = cur_r.cmp_req;
                        end
                        SEL_POWER: cur_nxt.rdata[3:0] = cur_r.power;
                        default: cur_nxt.rdata = 32'h0000_0000;
                    endcase
                end
            end
            BUS_ACC: begin
                if (done) begin
                    cur_nxt.st = BUS_IDLE;
                end
            end
            default: begin
                cur_nxt.st = BUS_IDLE;
            end
        endcase

        // register writes and read side effects
        if (done && pwrite) begin
            case (sel)
                SEL_CTRL0: cur_nxt.ctrl[0] = pwdata[7:0];
                SEL_CTRL1: cur_nxt.ctrl[1] = pwdata[7:0];
                SEL_MASK: cur_nxt.irq_mask = pwdata[1:0];
                SEL_POWER: cur_nxt.power = pwdata[3:0];
                default: cur_nxt.power = cur_nxt.power;
            endcase
        end
        // clear only what the read returned; events after setup survive
        if (done && !pwrite) begin
            if (sel == SEL_STAT) begin
                cur_nxt.irq_stat = cur_r.irq_stat & ~cur_r.rdata[1:0];
            end
            if (sel == SEL_WAKE) begin
                cur_nxt.stop_flag = cur_r.stop_flag & ~cur_r.rdata[WAKE_STOP_BIT];
            end
        end

        // power: off, or on and optionally kept in stop
        for (int c = 0; c < 2; c++) begin
            cur_nxt.pwr_on[c] = cur_r.power[PWR_ON_LSB + c]
                && (!stop_mode || cur_r.power[PWR_KEEP_LSB + c]);
        end

        // sticky events; a set wins over the read clear
        cur_nxt.irq_stat = cur_nxt.irq_stat | rise;
        hit = rise & cur_r.irq_mask;

        // vector acknowledge clears the request, new event wins
        if (vec_ack) begin
            cur_nxt.cmp_req = 1'b0;
        end
        if (hit != 2'h0) begin
            cur_nxt.cmp_req = 1'b1;
            if (stop_mode) begin
                cur_nxt.stop_rec = 1'b1;
                cur_nxt.stop_flag = 1'b1;
            end
        end

        // service request once out of stop with interrupts on
        cur_nxt.vec_req = cur_nxt.cmp_req && cpu_irq_en
            && !stop_mode;
        cur_nxt.irq = (cur_nxt.irq_stat & cur_nxt.irq_mask) != 2'h0;

        // timer trigger routing from synchronised levels
        for (int c = 0; c < 2; c++) begin
            case (route_of(cur_r.ctrl[c]))
                TRIG_T0: tr[0] = tr[0] | lvl[c];
                TRIG_T1: tr[1] = tr[1] | lvl[c];
                TRIG_T2: tr[2] = tr[2] | lvl[c];
                default: tr = tr;
            endcase
        end
        cur_nxt.trig = tr;
        cur_nxt.pin = lvl;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_r <= '0;
            cur_r.st <= BUS_IDLE;
            cur_r.ctrl[0] <= CTRL_RST;
            cur_r.ctrl[1] <= CTRL_RST;
            cur_r.irq_mask <= MASK_RST;
            cur_r.power <= POWER_RST;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // bus outputs
    assign prdata = cur_r.rdata;
    assign pready = cur_r.rdy;
    assign pslverr = cur_r.err;

    // analog selections straight from control bits; power enables from the registered power state
    assign comp0_pos_select = cur_r.ctrl[0][POS_SEL_BIT];
    assign comp1_pos_select = cur_r.ctrl[1][POS_SEL_BIT];
    assign comp0_neg_select = cur_r.ctrl[0][NEG_SEL_BIT];
    assign comp1_neg_select = cur_r.ctrl[1][NEG_SEL_BIT];
    assign comp0_ref_level_code = cur_r.ctrl[0][REF_MSB:REF_LSB];
    assign comp1_ref_level_code = cur_r.ctrl[1][REF_MSB:REF_LSB];
    assign comp0_power_on = cur_r.pwr_on[0];
    assign comp1_power_on = cur_r.pwr_on[1];

    // routed and pinned outputs
    assign timer_trig = cur_r.trig;
    assign comp0_out_pin = cur_r.pin[0];
    assign comp1_out_pin = cur_r.pin[1];

    // interrupt and wake
    assign irq = cur_r.irq;
    assign stop_recover = cur_r.stop_rec;
    assign cmp_vec_req = cur_r.vec_req;

endmodule

// file: tb/dcc_monitor.sv
// assertion checker for the dual comparator control block
`timescale 1ns/1ps
module dcc_monitor
    import dcc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire dcc_addr_t paddr,
    input wire dcc_word_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comp0_raw,
    input wire logic stop_mode,
    input wire logic cpu_irq_en,
    input wire logic [3:0] comp0_ref_level_code,
    input wire logic [3:0] comp1_ref_level_code,
    input wire logic comp0_power_on,
    input wire logic comp0_out_pin,
    input wire logic comp1_out_pin,
    input wire logic [2:0] timer_trig,
    input wire logic irq,
    input wire logic stop_recover,
    input wire logic cmp_vec_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    a_ready_next: assert property (setup_s |=> access_s)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_align: assert property (access_s ##0 paddr[1:0] != 2'b00 |-> pslverr && prdata == '0)
        else $error("misaligned access not refused");
    a_ref_reset: assert property ($past(sys_rst) |->
        comp0_ref_level_code == 4'h5 && comp1_ref_level_code == 4'h5)
        else $error("reference code not 0101 after reset");
    a_sync_rise: assert property ($rose(comp0_out_pin) |->
        $past(comp0_raw, 5))
        else $error("output rose without synchronised cause");
    a_sync_hold: assert property (
        (comp0_power_on && comp0_raw) [*6] |-> comp0_out_pin)
        else $error("output not following steady input");
    a_stop_pulse: assert property (stop_recover |=> !stop_recover)
        else $error("recovery pulse too long");
    a_stop_cause: assert property (stop_recover |-> $past(stop_mode) && irq)
        else $error("recovery without stop or request");
    a_vec_gate: assert property (cmp_vec_req |->
        $past(cpu_irq_en) && !$past(stop_mode))
        else $error("vector request while blocked");
    a_trig_idle: assert property (
        !comp0_out_pin && !comp1_out_pin |-> timer_trig == 3'h0)
        else $error("trigger with both outputs low");
endmodule
bind dcc_top dcc_monitor u_mon (.clk, .sys_rst, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .comp0_raw, .stop_mode, .cpu_irq_en, .comp0_ref_level_code, .comp1_ref_level_code,
    .comp0_power_on, .comp0_out_pin, .comp1_out_pin, .timer_trig, .irq, .stop_recover,
    .cmp_vec_req);

// file: tb/dcc_ana_model.sv
// behavioural comparator outputs feeding the control block
`timescale 1ns/1ps
module dcc_ana_model (
    input wire logic clk,
    input wire logic [1:0] level_cmd,
    input wire logic comp0_power_on,
    input wire logic comp1_power_on,
    output logic comp0_raw,
    output logic comp1_raw
);
    // powered: commanded level, off the clock edge; unpowered: chatter
    assign #3 comp0_raw = comp0_power_on ? level_cmd[0] : clk;
    assign #3 comp1_raw = comp1_power_on ? level_cmd[1] : clk;
endmodule

// file: tb/tb_dual_comparator_control.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module tb_dual_comparator_control;
    import dcc_pkg::*;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic stop_mode = 0, cpu_irq_en = 0, vec_ack = 0, err;
    logic [1:0] lvl = 2'h0;
    dcc_addr_t paddr = '0;
    dcc_word_t pwdata = '0, prdata, rd;
    logic pready, pslverr, comp0_raw, comp1_raw, irq, stop_recover, cmp_vec_req;
    logic comp0_pos_select, comp1_pos_select, comp0_neg_select, comp1_neg_select;
    logic comp0_power_on, comp1_power_on, comp0_out_pin, comp1_out_pin;
    logic [3:0] comp0_ref_level_code, comp1_ref_level_code;
    logic [2:0] timer_trig;
    int n_fail = 0, tests_run = 0, cyc = 0, n_wake = 0;
    dcc_top dut (.*);
    dcc_ana_model ana (.clk, .level_cmd(lvl), .comp0_power_on, .comp1_power_on, .comp0_raw,
        .comp1_raw);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stop_recover === 1'b1) n_wake++;
        if (cyc == 20000) begin
            n_fail++;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    function dcc_addr_t ad(input logic [11:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task apb(input logic w, input dcc_addr_t a, input dcc_word_t d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task drive_lvl(input logic [1:0] v);
        @(posedge clk);
        lvl <= v;
    endtask
    task t_regs;
        apb(0, ad(IDX_CTRL1), 0);
        chk("ctrl1 reset", 32'h14, rd);
        apb(0, ad(IDX_POWER), 0);
        chk("power reset", 32'h3, rd);
        apb(0, 16'h0004, 0);
        chk("unmapped err", 1, err);
        apb(0, ad(IDX_CTRL0) + 16'h1, 0);
        chk("misaligned err", 1, err);
        chk("ref0 reset", 4'h5, comp0_ref_level_code);
    endtask
    task t_fields;
        logic [7:0] v;
        logic [7:0] nv;
        for (int i = 0; i < 16; i++) begin
            v = {i[1], i[0], i[3:0], i[1:0]};
            nv = ~v;
            apb(1, ad(IDX_CTRL0), {24'hFFFFFF, v});
            apb(1, ad(IDX_CTRL1), {24'h0, nv});
            apb(0, ad(IDX_CTRL0), 0);
            chk("ctrl0 read", {24'h0, v}, rd);
            @(negedge clk);
            chk("pos0", v[7], comp0_pos_select);
            chk("neg0", v[6], comp0_neg_select);
            chk("ref0", v[5:2], comp0_ref_level_code);
            chk("pos1", nv[7], comp1_pos_select);
            chk("neg1", nv[6], comp1_neg_select);
            chk("ref1", nv[5:2], comp1_ref_level_code);
        end
    endtask
    task t_trig;
        apb(1, ad(IDX_CTRL1), 0);
        for (int t = 0; t < 4; t++) begin
            apb(1, ad(IDX_CTRL0), t);
            drive_lvl(2'b01);
            wt(4);
            chk("out early", 0, comp0_out_pin);
            wt(1);
            chk("out pin", 1, comp0_out_pin);
            chk("trig", t == 0 ? 0 : 1 << (t - 1), timer_trig);
            drive_lvl(2'b00);
            wt(5);
            chk("trig idle", 0, timer_trig);
        end
    endtask
    task t_irq;
        apb(0, ad(IDX_IRQ_STAT), 0);
        apb(1, ad(IDX_IRQ_MASK), 1);
        apb(1, ad(IDX_CTRL1), 32'h1);
        drive_lvl(2'b11);
        wt(5);
        chk("irq", 1, irq);
        chk("out1 pin", 1, comp1_out_pin);
        chk("trig both", 32'h5, timer_trig);
        apb(0, ad(IDX_IRQ_STAT), 0);
        chk("stat", 3, rd);
        @(negedge clk);
        chk("irq clear", 0, irq);
        drive_lvl(2'b00);
        wt(5);
        drive_lvl(2'b10);
        wt(5);
        chk("irq masked", 0, irq);
        drive_lvl(2'b00);
    endtask
    task t_stop;
        apb(0, ad(IDX_IRQ_STAT), 0);
        apb(1, ad(IDX_POWER), 32'h7);
        n_wake = 0;
        @(posedge clk);
        stop_mode <= 1'b1;
        cpu_irq_en <= 1'b1;
        lvl <= 2'b01;
        wt(6);
        chk("pwr kept", 1, comp0_power_on);
        chk("pwr dropped", 0, comp1_power_on);
        chk("wake pulses", 1, n_wake);
        chk("irq stop", 1, irq);
        chk("vec in stop", 0, cmp_vec_req);
        apb(0, ad(IDX_WAKE_STAT), 0);
        chk("wake stat", 3, rd);
        @(posedge clk);
        stop_mode <= 1'b0;
        wt(1);
        chk("vec req", 1, cmp_vec_req);
        @(posedge clk);
        vec_ack <= 1'b1;
        @(posedge clk);
        vec_ack <= 1'b0;
        apb(0, ad(IDX_WAKE_STAT), 0);
        chk("wake clear", 0, rd);
        drive_lvl(2'b00);
    endtask
    task t_power;
        apb(1, ad(IDX_POWER), 32'h2);
        apb(0, ad(IDX_IRQ_STAT), 0);
        drive_lvl(2'b01);
        wt(6);
        chk("pwr off", 0, comp0_power_on);
        chk("out off", 0, comp0_out_pin);
        apb(0, ad(IDX_IRQ_STAT), 0);
        chk("no event", 0, rd);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_fields;
        t_trig;
        t_irq;
        t_stop;
        t_power;
        conclude;
    end
endmodule
